/* File: bench/tb_vertex_shader_state_decode.sv */
`timescale 1ns/1ps
module tb_vertex_shader_state_decode;
    import vsd_pkg::*;
    logic clk_i = 0, rst_n_i = 0, hsel = 0, hwrite = 0, cv = 0, vv = 0, bnd = 0;
    logic [1:0] htrans = 0;
    logic [31:0] haddr = 0, hwdata = 0, cd = 0, rd, hrdata, vexp = 0, p[4], seed = 32'h4990_b7e9;
    vsd_vin_s vi = '0;
    logic hrdy, cr, vr, tv, tr, td, pfv, pcv, inv, ovv, pr, fp, ioe, swe, st;
    logic [5:0] ts, len, off;
    logic [7:0] pfc, pf, btc;
    logic [21:0] base;
    logic [3:0] sz;
    logic [4:0] general_register_file;
    logic [15:0] ha, hb;
    logic [25:0] kp;
    vsd_thr_s thr, th;
    vsd_vout_s vo, ov;
    vsd_pcs_t pcs, pc;
    int errors = 0, compares = 0, ninv = 0, nthr = 0, i, k;
    vsd_state_decode #(.IDLE_CYC(2)) dut_u (.clk_i, .rst_n_i, .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy),
        .hreadyout_o(hrdy), .hresp_o(), .hrdata_o(hrdata), .cmd_valid_i(cv), .cmd_data_i(cd),
        .cmd_ready_o(cr), .vtx_valid_i(vv), .vtx_i(vi), .vtx_ready_o(vr), .draw_bnd_i(bnd),
        .thr_valid_o(tv), .thr_o(thr), .thr_ready_i(tr), .thr_done_i(td), .thr_done_slot_i(ts),
        .vout_valid_o(ovv), .vout_o(vo), .vout_ready_i(1'b1), .cache_inv_o(inv), .pf_valid_o(pfv),
        .pf_count_o(pfc), .pcs_valid_o(pcv), .pcs_o(pcs));
    vsd_disp_model part_u (.clk_i, .valid_i(tv), .slot_i(thr.slot), .ready_o(tr), .done_o(td),
        .dslot_o(ts));
    always #5 clk_i = ~clk_i;
    // capture what the design hands out
    always @(posedge clk_i) begin
        if (tv && tr) th <= thr;
        if (tv && tr) nthr <= nthr + 1;
        if (pfv) pf <= pfc;
        if (pcv) pc <= pcs;
        if (ovv) ov <= vo;
        if (inv) ninv <= ninv + 1;
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            errors++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
        @(posedge clk_i);
        {hsel, htrans, haddr, hwrite} <= {1'b1, 2'b10, a, w};
        do @(posedge clk_i); while (!hrdy);
        {hsel, htrans, hwdata} <= {1'b0, 2'b00, wd};
        do @(posedge clk_i); while (!hrdy);
        rd = hrdata;
    endtask : ahb
    // one dword to the command port or one vertex to the fetch port
    task automatic put(input bit v, input logic [31:0] d);
        @(posedge clk_i);
        if (v) {vv, vi} <= {1'b1, d[16:0]};
        else {cv, cd} <= {1'b1, d};
        do @(negedge clk_i); while (!(v ? vr : cr));
        @(posedge clk_i);
        {vv, cv} <= 2'b00;
    endtask : put
    task automatic complete_run;
        $display("compares=%0d errors=%0d", compares, errors);
        if (errors == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : complete_run
    initial begin
        #300000;
        errors++;
        complete_run;
    end
    initial begin
        repeat (16) @(posedge clk_i);
        rst_n_i <= 1;
        ahb(0, 32'h0, 0);
        chk(rd, 32'h1);
        ahb(0, 32'h40, 0);
        chk(rd, 32'h0);
        ahb(1, 32'h0, 32'h3);
        for (int t = 0; t < 4; t++) begin
            {btc, pr, fp, ioe, swe, st} = $random(seed);
            {base, sz} = $random(seed) & 32'hffff_fff7;
            {general_register_file, len, off} = $random(seed) | 32'h40;
            kp = $random(seed);
            {ha, hb} = $random(seed);
            put(0, 32'h7810_0004);
            put(0, {kp, 6'h0});
            put(0, {6'h0, btc, pr, fp, 2'h0, ioe, 5'h0, swe, 7'h0});
            put(0, {base, 6'h0, sz});
            put(0, {7'h0, general_register_file, 3'h0, len, 1'h0, off, 4'h0});
            put(0, {7'(t), 14'h0, st, 10'h3});
            k = nthr;
            repeat (4) @(posedge clk_i);
            chk(pf, btc);
            chk(ninv, 2 * t + 1);
            put(1, {ha, 1'b1});
            put(1, {hb, 1'b0});
            for (i = 0; i < 60 && nthr == k; i++) @(posedge clk_i);
            chk({th.prio, th.fpm, th.tcw[13:12]}, {pr, fp, swe, ioe});
            chk({th.grf_start, th.urb_regs, th.urb_off, th.scr_size}, {general_register_file, len, 1'b0, off, sz});
            chk(22'(base + (22'(th.slot) << sz)), base + (22'(th.slot) << sz));
            chk(th.scr_off, 22'(base + (22'(th.slot) << sz)));
            chk({th.h0, th.h1}, {ha, hb});
            chk({th.kptr, th.nvtx}, {kp, 2'h2});
            vexp += st ? 2 : 0;
            ahb(0, 32'h8, 0);
            chk(rd, vexp);
            bnd <= 1;
            @(posedge clk_i);
            bnd <= 0;
            repeat (3) @(posedge clk_i);
            $display("test %0d done", t);
        end
        // shading off, cache on, roomy thread ceiling
        for (k = 0; k < 6; k++) put(0, k == 0 ? 32'h7810_0004 : k == 5 ? 32'h7600_0000 : 32'h0);
        for (k = 0; k < 2; k++) begin
            put(1, {ha, k[0]});
            repeat (2) @(posedge clk_i);
            chk(ov, {ha, k[0], !k[0]});
        end
        put(0, 32'h7815_0003);
        foreach (p[j]) begin
            p[j] = $random(seed);
            put(0, p[j]);
        end
        repeat (4) @(posedge clk_i);
        foreach (p[j]) chk(pc[j], p[j]);
        $display("test tail done");
        complete_run;
    end
endmodule : tb_vertex_shader_state_decode

/* File: bench/vsd_disp_model.sv */
`timescale 1ns/1ps
module vsd_disp_model (
    input  wire logic       clk_i,   // clock
    input  wire logic       valid_i, // request offered
    input  wire logic [5:0] slot_i,  // its slot
    output logic            ready_o, // request taken
    output logic            done_o,  // retire pulse
    output logic      [5:0] dslot_o  // retired slot
);
    logic [5:0] q[$];                // live slots, oldest first
    initial begin
        ready_o = 0;
        done_o = 0;
        dslot_o = 0;
    end
    // random stalls and late retires; slot line toggles while unused
    always @(posedge clk_i) begin
        done_o <= 0;
        dslot_o <= ~dslot_o;
        if (valid_i && ready_o) q.push_back(slot_i);
        ready_o <= $random;
        if (q.size() > 0 && ($random & 3) == 0) begin
            done_o <= 1;
            dslot_o <= q.pop_front();
        end
    end
endmodule : vsd_disp_model

/* File: rtl/vsd_params.svh */
`ifndef VSD_PARAMS_SVH
`define VSD_PARAMS_SVH
// packet header fields
`define VSD_HDR_TYPE     31:29
`define VSD_HDR_SUB      28:27
`define VSD_HDR_OP       26:24
`define VSD_HDR_SUBOP    23:16
`define VSD_HDR_LEN      7:0
`define VSD_TYPE_GFX     3'h3
`define VSD_SUB_3D       2'h3
`define VSD_OP_PIPE      3'h0
`define VSD_SUBOP_STATE  8'h10
`define VSD_SUBOP_PCONST 8'h15
// state packet fields, by dword
`define VSD_KPTR         31:6
`define VSD_SINGLE       31
`define VSD_BTC          25:18
`define VSD_PRIO         17
`define VSD_FPM          16
`define VSD_IOE          13
`define VSD_SWE          7
`define VSD_SCR_BASE     31:10
`define VSD_SCR_SIZE     3:0
`define VSD_GRF_START    24:20
`define VSD_RD_LEN       16:11
`define VSD_RD_OFF       9:4
`define VSD_MAXTHR       31:25
`define VSD_STAT_EN      10
`define VSD_VC_DIS       1
`define VSD_SH_EN        0
// thread control word bits
`define VSD_TCW_IOE      12
`define VSD_TCW_SWE      13
// limits and timing
`define VSD_MAXTHR_MAX   7'h3b
`define VSD_MAX_THREADS  60
`define VSD_IDLE_NS      80
`define VSD_CLK_NS       10
// register map and fields
`define VSD_REG_CTRL     8'h00
`define VSD_REG_STATUS   8'h04
`define VSD_REG_VCNT     8'h08
`define VSD_REG_TCNT     8'h0c
`define VSD_CTRL_RST     32'h0000_0001
`define VSD_CTRL_DEC_EN  0
`define VSD_CTRL_STCLR   1
`define VSD_ST_ACT       6:0
`define VSD_ST_PEND      8
`define VSD_ST_CMT       9
`define VSD_ST_SHEN      10
`define VSD_ST_CEN       11
`endif

/* File: rtl/vsd_pkg.sv */
package vsd_pkg;
    // decoder states
    typedef enum logic [1:0] {
        DS_HDR  = 2'b01,
        DS_BODY = 2'b10
    } vsd_dec_e;
    // vertex from the fetch unit
    typedef struct packed {
        logic [15:0] handle;
        logic        hit;
    } vsd_vin_s;
    // vertex leaving without a thread
    typedef struct packed {
        logic [15:0] handle;
        logic        hit;
        logic        urb_wr;
    } vsd_vout_s;
    // thread request to the dispatcher
    typedef struct packed {
        logic [25:0] kptr;
        logic        prio;
        logic        fpm;
        logic [31:0] tcw;
        logic [21:0] scr_off;
        logic [3:0]  scr_size;
        logic [4:0]  grf_start;
        logic [6:0]  urb_regs;
        logic [5:0]  urb_off;
        logic [1:0]  nvtx;
        logic [15:0] h0;
        logic [15:0] h1;
        logic [5:0]  slot;
    } vsd_thr_s;
    // push constant load: four pointer dwords
    typedef logic [3:0][31:0] vsd_pcs_t;
endpackage : vsd_pkg

/* File: rtl/vsd_slot_alloc.sv */
`timescale 1ns/1ps
module vsd_slot_alloc #(
    parameter int NSLOT = 60
) (
    input  wire logic       clk_i,       // clock
    input  wire logic       rst_n_i,     // sync reset
    input  wire logic       alloc_i,     // take the offered slot
    input  wire logic       free_i,      // thread retired
    input  wire logic [5:0] free_slot_i, // its slot
    input  wire logic [6:0] limit_i,     // thread ceiling
    output logic            avail_o,     // a slot may be taken
    output logic      [5:0] slot_o,      // offered slot
    output logic      [6:0] count_o      // live threads
);
    logic [NSLOT-1:0] used_q;  // slot busy map
    logic [6:0]       count_q; // busy slots
    logic             found;   // a free slot exists

    if (NSLOT < 1 || NSLOT > 64) begin : g_chk
        $error("slot count must be 1..64");
    end

    // lowest free slot; fixed priority keeps it simple
    always_comb begin
        found  = 1'b0;
        slot_o = 6'h0;
        for (int i = NSLOT - 1; i >= 0; i--) begin
            if (!used_q[i]) begin
                found  = 1'b1;
                slot_o = 6'(i);
            end
        end
    end
    assign avail_o = found && (count_q < limit_i);
    assign count_o = count_q;

    // busy map and count
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            used_q  <= '0;
            count_q <= 7'h0;
        end else begin
            if (free_i) used_q[free_slot_i] <= 1'b0;
            if (alloc_i) used_q[slot_o] <= 1'b1;
            count_q <= count_q + 7'(alloc_i) - 7'(free_i && used_q[free_slot_i]);
        end
    end

    a_slot_unique: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE_08
        alloc_i |-> avail_o && !used_q[slot_o]) else $error("slot handed out twice");
endmodule : vsd_slot_alloc

/* File: rtl/vsd_state_decode.sv */
`timescale 1ns/1ps
// Contract
// RULE_01: entry count only drives binding prefetch
// RULE_02: software zeroes count for huge tables
// RULE_03: bit 17 picks thread dispatch priority
// RULE_04: bit 16 sets initial float mode
// RULE_05: illegal opcode enable to control bit 12
// RULE_06: software exception enable to bit 13
// RULE_07: scratch base in 1 KB units
// RULE_08: each thread gets own scratch portion
// RULE_09: scratch size is 1 KB shifted
// RULE_10: software reserves enough scratch memory
// RULE_11: scratch size forwarded unchanged
// RULE_12: payload start register from dword 4
// RULE_13: vertex registers twice read length
// RULE_14: software never programs read length zero
// RULE_15: read offset shared by all entries
// RULE_16: never exceed thread count limit
// RULE_17: statistics move only when enabled
// RULE_18: cache off shades all, else misses
// RULE_19: unshaded misses written to return buffer; code sets urb_wr only while the cache is enabled
// RULE_20: invalidate cache on listed events
// RULE_21: shading off passes vertices unmodified
// RULE_22: recognise push constant packet header
// RULE_23: kernel pointer from dword 1
// RULE_24: single dispatch forces one vertex
// RULE_25: vertices leave in arrival order
// RULE_26: software zeroes reserved bits
// RULE_27: new state applies to later vertices
`include "vsd_params.svh"
module vsd_state_decode #(
    parameter int NSLOT    = `VSD_MAX_THREADS,        // scratch slots
    parameter int IDLE_CYC = `VSD_IDLE_NS / `VSD_CLK_NS // quiet wait
) (
    input  wire logic              clk_i,        // 100 MHz clock
    input  wire logic              rst_n_i,      // sync reset
    // register bus
    input  wire logic              hsel_i,       // slave select
    input  wire logic [31:0]       haddr_i,      // address
    input  wire logic [1:0]        htrans_i,     // transfer type
    input  wire logic              hwrite_i,     // write
    input  wire logic [2:0]        hsize_i,      // word only
    input  wire logic [31:0]       hwdata_i,     // write data
    input  wire logic              hready_i,     // bus ready
    output logic                   hreadyout_o,  // never stalls
    output logic                   hresp_o,      // always okay
    output logic [31:0]            hrdata_o,     // read data
    // command stream
    input  wire logic              cmd_valid_i,  // dword offered
    input  wire logic [31:0]       cmd_data_i,   // dword
    output logic                   cmd_ready_o,  // dword taken
    // vertices from fetch unit
    input  wire logic              vtx_valid_i,  // vertex offered
    input  wire vsd_pkg::vsd_vin_s vtx_i,        // vertex
    output logic                   vtx_ready_o,  // vertex taken
    input  wire logic              draw_bnd_i,   // draw/instance edge
    // thread requests
    output logic                   thr_valid_o,  // request valid
    output vsd_pkg::vsd_thr_s      thr_o,        // request
    input  wire logic              thr_ready_i,  // dispatcher took it
    input  wire logic              thr_done_i,   // thread retired
    input  wire logic [5:0]        thr_done_slot_i, // its slot
    // pass-through vertices
    output logic                   vout_valid_o, // vertex out
    output vsd_pkg::vsd_vout_s     vout_o,       // vertex
    input  wire logic              vout_ready_i, // taken
    // side outputs
    output logic                   cache_inv_o,  // invalidate pulse
    output logic                   pf_valid_o,   // prefetch pulse
    output logic [7:0]             pf_count_o,   // entries to fetch
    output logic                   pcs_valid_o,  // constant load pulse
    output vsd_pkg::vsd_pcs_t      pcs_o         // constant pointers
);
    import vsd_pkg::*;

    if (IDLE_CYC < 1 || IDLE_CYC > 15) begin : g_chk
        $error("idle wait must be 1..15 cycles");
    end

    ////////////////////////////////////////////////////////////////////
    // header match, used for both packet kinds
    function automatic logic hdr_is(input logic [31:0] w, input logic [7:0] sub);
        hdr_is = (w[`VSD_HDR_TYPE] == `VSD_TYPE_GFX) && (w[`VSD_HDR_SUB] == `VSD_SUB_3D)
              && (w[`VSD_HDR_OP] == `VSD_OP_PIPE) && (w[`VSD_HDR_SUBOP] == sub);
    endfunction : hdr_is

    vsd_dec_e    st_q;        // decoder state
    logic [8:0]  rem_q;       // dwords left in packet
    logic [7:0]  idx_q;       // dword index in packet
    logic        is_st_q;     // shading state packet
    logic        is_pc_q;     // push constant packet
    logic        cmt_q;       // state waits to apply
    logic        pcs_v_q;     // constant load pulse
    logic [31:0] sh_q [8];    // captured dwords
    logic [31:0] live_q [8];  // applied dwords
    vsd_pcs_t    pc_q;        // constant pointers
    logic [31:0] ctrl_q;      // control register
    logic        pend_q;      // unpaired miss held
    logic [15:0] pend_h_q;    // its handle
    logic [3:0]  idle_q;      // quiet cycles with miss held
    logic        thr_v_q;     // request stage full
    vsd_thr_s    thr_q;       // request stage
    logic        vo_v_q;      // pass stage full
    vsd_vout_s   vo_q;        // pass stage
    logic        inv_q;       // invalidate pulse
    logic        pf_v_q;      // prefetch pulse
    logic [7:0]  pf_cnt_q;    // prefetch count
    logic        wr_q;        // write data phase
    logic [7:0]  wa_q;        // its address
    logic [31:0] hrdata_q;    // read data
    vsd_thr_s    thr_d;       // next request

    ////////////////////////////////////////////////////////////////////
    // applied state fields
    wire       sh_en    = live_q[5][`VSD_SH_EN];          // RULE_21
    wire       cache_en = !live_q[5][`VSD_VC_DIS];
    wire       single_q = live_q[2][`VSD_SINGLE];         // RULE_24
    wire       stat_en  = live_q[5][`VSD_STAT_EN];
    wire [6:0] thr_fld  = live_q[5][`VSD_MAXTHR];
    // out-of-range counts clamp so the ceiling stays real
    wire [6:0] max_thr  = (thr_fld > `VSD_MAXTHR_MAX ? `VSD_MAXTHR_MAX : thr_fld) + 7'h1; // RULE_16

    ////////////////////////////////////////////////////////////////////
    // command decoder
    wire cmd_go  = cmd_valid_i && cmd_ready_o;
    wire do_cmt  = cmt_q && !pend_q; // lone miss flushed first
    wire last_dw = (st_q == DS_BODY) && cmd_go && (rem_q == 9'h001);
    assign cmd_ready_o = ctrl_q[`VSD_CTRL_DEC_EN] && !cmt_q;

    // header takes length, body fills shadow copy
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            st_q    <= DS_HDR;
            rem_q   <= 9'h000;
            idx_q   <= 8'h00;
            is_st_q <= 1'b0;
            is_pc_q <= 1'b0;
            cmt_q   <= 1'b0;
            pcs_v_q <= 1'b0;
        end else begin
            pcs_v_q <= last_dw && is_pc_q;
            if (do_cmt) cmt_q <= 1'b0;
            else if (last_dw && is_st_q) cmt_q <= 1'b1;
            case (st_q)
                DS_HDR: if (cmd_go) begin
                    st_q    <= DS_BODY;
                    rem_q   <= {1'b0, cmd_data_i[`VSD_HDR_LEN]} + 9'h001;
                    idx_q   <= 8'h01;
                    is_st_q <= hdr_is(cmd_data_i, `VSD_SUBOP_STATE);
                    is_pc_q <= hdr_is(cmd_data_i, `VSD_SUBOP_PCONST); // RULE_22
                end
                DS_BODY: if (cmd_go) begin
                    idx_q <= idx_q + 8'h01;
                    rem_q <= rem_q - 9'h001;
                    if (rem_q == 9'h001) st_q <= DS_HDR;
                end
                default: st_q <= DS_HDR;
            endcase
        end
    end

    // packet storage; fields captured on acceptance
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < 8; i++) begin
                sh_q[i]   <= 32'h0000_0000;
                live_q[i] <= 32'h0000_0000;
            end
            pc_q <= '0;
        end else begin
            if (st_q == DS_BODY && cmd_go && is_st_q && idx_q <= 8'h05)
                sh_q[idx_q[2:0]] <= cmd_data_i; // RULE_27
            if (st_q == DS_BODY && cmd_go && is_pc_q && idx_q <= 8'h04)
                pc_q[idx_q[1:0] - 2'h1] <= cmd_data_i; // RULE_22
            if (do_cmt) begin
                for (int i = 0; i < 8; i++) live_q[i] <= sh_q[i]; // RULE_27
            end
        end
    end
    assign pcs_valid_o = pcs_v_q;
    assign pcs_o       = pc_q;

    ////////////////////////////////////////////////////////////////////
    // cache invalidate at draw edge or at a state change with the cache off before or after it or that flips shading, prefetch at a state change that enables shading
    wire new_sh  = sh_q[5][`VSD_SH_EN];
    wire cache_off = !cache_en || sh_q[5][`VSD_VC_DIS];
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            inv_q    <= 1'b0;
            pf_v_q   <= 1'b0;
            pf_cnt_q <= 8'h00;
        end else begin
            inv_q  <= draw_bnd_i || (do_cmt && (cache_off || (new_sh != sh_en))); // RULE_20
            pf_v_q <= do_cmt && new_sh;
            if (do_cmt) pf_cnt_q <= sh_q[2][`VSD_BTC]; // RULE_01
        end
    end
    assign cache_inv_o = inv_q;
    assign pf_valid_o  = pf_v_q;
    assign pf_count_o  = pf_cnt_q;

    ////////////////////////////////////////////////////////////////////
    // vertex routing and pairing
    logic       slot_ok; // allocator can give a slot
    logic [5:0] slot;    // offered slot
    logic [6:0] act_cnt; // live threads
    wire hit      = cache_en && vtx_i.hit;
    wire is_miss  = sh_en && !hit;                 // RULE_18
    wire issue_ok = (!thr_v_q || thr_ready_i) && slot_ok;
    wire vo_ok    = !vo_v_q || vout_ready_i;
    // a held miss goes alone when it would block output
    wire fl_need  = pend_q && (cmt_q || (vtx_valid_i ? !is_miss : idle_q == 4'(IDLE_CYC))); // RULE_25
    assign vtx_ready_o = !cmt_q && (is_miss ? ((single_q || pend_q) ? issue_ok : 1'b1)
                                            : (!pend_q && vo_ok));
    wire vtx_go   = vtx_valid_i && vtx_ready_o;
    wire pair_go  = vtx_go && is_miss && (single_q || pend_q);
    wire issue    = issue_ok && (fl_need || pair_go);
    wire hold_go  = vtx_go && is_miss && !single_q && !pend_q;
    wire pass_go  = vtx_go && !is_miss;

    // next thread request from applied state
    always_comb begin
        thr_d           = '0;
        thr_d.kptr      = live_q[1][`VSD_KPTR];      // RULE_23
        thr_d.prio      = live_q[2][`VSD_PRIO];      // RULE_03
        thr_d.fpm       = live_q[2][`VSD_FPM];       // RULE_04
        thr_d.tcw[`VSD_TCW_IOE] = live_q[2][`VSD_IOE]; // RULE_05
        thr_d.tcw[`VSD_TCW_SWE] = live_q[2][`VSD_SWE]; // RULE_06
        // per-thread portion: base plus slot shifted left by size
        thr_d.scr_off   = live_q[3][`VSD_SCR_BASE] + (22'(slot) << live_q[3][`VSD_SCR_SIZE]); // RULE_07 RULE_08 RULE_09
        thr_d.scr_size  = live_q[3][`VSD_SCR_SIZE];  // RULE_11
        thr_d.grf_start = live_q[4][`VSD_GRF_START]; // RULE_12
        thr_d.urb_regs  = {live_q[4][`VSD_RD_LEN], 1'b0}; // RULE_13
        thr_d.urb_off   = live_q[4][`VSD_RD_OFF];    // RULE_15
        thr_d.slot      = slot;
        if (fl_need || single_q) begin
            thr_d.nvtx = 2'h1; // RULE_24
            thr_d.h0   = fl_need ? pend_h_q : vtx_i.handle;
        end else begin
            thr_d.nvtx = 2'h2;
            thr_d.h0   = pend_h_q;
            thr_d.h1   = vtx_i.handle;
        end
    end

    // held miss and its quiet timer
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pend_q   <= 1'b0;
            pend_h_q <= 16'h0000;
            idle_q   <= 4'h0;
        end else begin
            if (issue) pend_q <= 1'b0;
            else if (hold_go) pend_q <= 1'b1;
            if (hold_go) pend_h_q <= vtx_i.handle;
            if (!pend_q || vtx_valid_i) idle_q <= 4'h0;
            else if (idle_q != 4'(IDLE_CYC)) idle_q <= idle_q + 4'h1;
        end
    end

    // output stages for requests and pass-through
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            thr_v_q <= 1'b0;
            thr_q   <= '0;
            vo_v_q  <= 1'b0;
            vo_q    <= '0;
        end else begin
            if (issue) thr_q <= thr_d;
            if (issue) thr_v_q <= 1'b1;
            else if (thr_ready_i) thr_v_q <= 1'b0;
            if (pass_go) begin
                vo_q.handle <= vtx_i.handle;
                vo_q.hit    <= hit;
                vo_q.urb_wr <= !sh_en && !hit && cache_en; // RULE_19 RULE_21
            end
            if (pass_go) vo_v_q <= 1'b1;
            else if (vout_ready_i) vo_v_q <= 1'b0;
        end
    end
    assign thr_valid_o  = thr_v_q;
    assign thr_o        = thr_q;
    assign vout_valid_o = vo_v_q;
    assign vout_o       = vo_q;

    vsd_slot_alloc #(.NSLOT(NSLOT)) u_slot (
        .clk_i       (clk_i),
        .rst_n_i     (rst_n_i),
        .alloc_i     (issue),
        .free_i      (thr_done_i),
        .free_slot_i (thr_done_slot_i),
        .limit_i     (max_thr), // RULE_16
        .avail_o     (slot_ok),
        .slot_o      (slot),
        .count_o     (act_cnt)
    );

    ////////////////////////////////////////////////////////////////////
    // register bus: zero wait, okay always
    logic [31:0] st_word; // status view
    logic [31:0] vcnt;    // shaded vertices
    logic [31:0] tcnt;    // threads issued
    wire ahb_go = hsel_i && htrans_i[1] && hready_i;
    wire stclr  = wr_q && (wa_q == `VSD_REG_CTRL) && hwdata_i[`VSD_CTRL_STCLR];
    always_comb begin
        st_word              = 32'h0000_0000;
        st_word[`VSD_ST_ACT]  = act_cnt;
        st_word[`VSD_ST_PEND] = pend_q;
        st_word[`VSD_ST_CMT]  = cmt_q;
        st_word[`VSD_ST_SHEN] = sh_en;
        st_word[`VSD_ST_CEN]  = cache_en;
    end
    // unmapped words read zero
    wire [31:0] rd_mux = (haddr_i[7:0] == `VSD_REG_CTRL)   ? ctrl_q  :
                         (haddr_i[7:0] == `VSD_REG_STATUS) ? st_word :
                         (haddr_i[7:0] == `VSD_REG_VCNT)   ? vcnt    :
                         (haddr_i[7:0] == `VSD_REG_TCNT)   ? tcnt    : 32'h0000_0000;

    // address phase captured, write done in data phase
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            wr_q     <= 1'b0;
            wa_q     <= 8'h00;
            hrdata_q <= 32'h0000_0000;
            ctrl_q   <= `VSD_CTRL_RST;
        end else begin
            wr_q <= ahb_go && hwrite_i;
            if (ahb_go) wa_q <= haddr_i[7:0];
            if (ahb_go && !hwrite_i) hrdata_q <= rd_mux;
            // clear bit is a strobe, never stored
            if (wr_q && wa_q == `VSD_REG_CTRL) ctrl_q <= {hwdata_i[31:2], 1'b0, hwdata_i[0]};
        end
    end
    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;
    assign hrdata_o    = hrdata_q;

    vsd_stats u_stats (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .en_i    (stat_en && sh_en), // RULE_17
        .clr_i   (stclr),
        .inc_i   ({1'b0, issue, issue ? thr_d.nvtx : 2'h0}),
        .vcnt_o  (vcnt),
        .tcnt_o  (tcnt)
    );

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_commit;
        cmt_q && !pend_q;
    endsequence
    sequence s_shade_flip;
        s_commit ##0 (new_sh != sh_en);
    endsequence

    a_thr_limit: assert property (act_cnt <= max_thr) // RULE_16
        else $error("thread ceiling exceeded");
    a_state_apply: assert property (s_commit |=> live_q[5] == $past(sh_q[5]) && !cmt_q) // RULE_27
        else $error("captured state not applied");
    a_inval_flip: assert property (s_shade_flip |=> cache_inv_o) // RULE_20
        else $error("no invalidate on shading change");
    a_single_one: assert property (issue && single_q |=> thr_valid_o && thr_o.nvtx == 2'h1) // RULE_24
        else $error("two vertices under single dispatch");
    a_hit_bypass: assert property (vtx_go && sh_en && hit |=> vout_valid_o && vout_o.hit) // RULE_18
        else $error("cache hit sent to a thread");
    a_order_keep: assert property (pend_q && vtx_valid_i && !is_miss |-> !vtx_ready_o) // RULE_25
        else $error("vertex overtook held miss");
    a_pcs_after: assert property (pcs_valid_o |-> $past(is_pc_q) && $past(last_dw)) // RULE_22
        else $error("constant load without its packet");
    a_off_pass: assert property (vtx_go && !sh_en |-> !issue ##1 vout_valid_o) // RULE_21
        else $error("vertex shaded while disabled");
endmodule : vsd_state_decode

/* File: rtl/vsd_stats.sv */
`timescale 1ns/1ps
module vsd_stats (
    input  wire logic        clk_i,   // clock
    input  wire logic        rst_n_i, // sync reset
    input  wire logic        en_i,    // gathering on
    input  wire logic        clr_i,   // software clear
    input  wire logic [3:0]  inc_i,   // {threads, vertices} steps
    output logic      [31:0] vcnt_o,  // shaded vertices
    output logic      [31:0] tcnt_o   // threads issued
);
    logic [31:0] cnt_q [2]; // counters

    // one counter per event kind
    for (genvar g = 0; g < 2; g++) begin : g_cnt
        always_ff @(posedge clk_i) begin
            if (!rst_n_i || clr_i) cnt_q[g] <= 32'h0000_0000;
            else if (en_i) cnt_q[g] <= cnt_q[g] + 32'(inc_i[2*g +: 2]); // RULE_17
        end
    end
    assign vcnt_o = cnt_q[0];
    assign tcnt_o = cnt_q[1];

    a_stats_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE_17
        !en_i && !clr_i |=> $stable(vcnt_o) && $stable(tcnt_o)) else $error("counter moved while off");
endmodule : vsd_stats
